// >>> src/sim_monitor.sv
// Input monitor for e-stop and guard interlock contacts.
// Assumes raw contact and reset pins from the field, config held stable.
`timescale 1ns/1ps
`default_nettype none

module sim_monitor
    import sim_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int TP_LEN_CYC = TP_LEN_CYC_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_first_contact_input,
    input wire logic i_second_contact_input,
    input wire logic i_reset_input,
    input wire logic [1:0] i_mode,
    input wire logic i_input_type,
    input wire logic i_reset_enable,
    input wire logic i_reset_monitored,
    input wire logic i_cable_test_enable,
    input wire logic i_startup_test_enable,
    input wire logic [7:0] i_filter_ms,
    input wire logic i_simul_enable,
    input wire logic [7:0] i_simul_ms,
    input wire logic i_error_enable,
    output logic o_output,
    output logic o_error,
    output logic [1:0] o_test_out
);

    // Pin synchronisers: bit 0/1 contacts, bit 2 reset
    logic [2:0] sync1, sync2, sync3, stab;
    logic [2:0] next_stab;
    always_comb begin
        next_stab = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & stab);
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            stab <= 3'h0;
        end else begin
            sync1 <= {i_reset_input, i_second_contact_input,
                      i_first_contact_input};
            sync2 <= sync1;
            sync3 <= sync2;
            stab <= next_stab;
        end
    end

    // Millisecond tick
    logic [15:0] ms_cnt, next_ms_cnt;
    logic ms_tick;
    always_comb begin
        ms_tick = (ms_cnt == 16'(MS_CYC - 1));
        next_ms_cnt = ms_tick ? 16'h0 : ms_cnt + 16'h1;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) ms_cnt <= 16'h0;
        else ms_cnt <= next_ms_cnt;
    end

    // Configuration decode
    logic two_ch, mixed;
    logic [7:0] filt_eff;
    always_comb begin
        two_ch = (i_mode == MODE_DUAL) ||
                 ((i_mode == MODE_ESTOP) && i_input_type);
        mixed = (i_mode == MODE_DUAL) && i_input_type;
        if (i_filter_ms < FILT_MIN_MS) filt_eff = FILT_MIN_MS;
        else if (i_filter_ms > FILT_MAX_MS) filt_eff = FILT_MAX_MS;
        else filt_eff = i_filter_ms;
    end

    // Test pulse windows, alternating channels in two-channel modes, channel 0 only otherwise
    logic win, next_win, sel, next_sel, tp_err;
    logic [7:0] tp_ms, next_tp_ms;
    logic [15:0] win_cnt, next_win_cnt;
    logic [1:0] next_test_out;
    logic win_last;
    always_comb begin
        next_win = win;
        next_sel = sel;
        next_tp_ms = tp_ms;
        next_win_cnt = win_cnt;
        win_last = win && (win_cnt == 16'(TP_LEN_CYC - 1));
        if (win) begin
            next_win_cnt = win_cnt + 16'h1;
            if (win_last) next_win = 1'b0;
        end else if (ms_tick && i_cable_test_enable) begin
            if (tp_ms == TP_PERIOD_MS - 8'h1) begin
                next_tp_ms = 8'h0;
                next_win = 1'b1;
                next_win_cnt = 16'h0;
                next_sel = two_ch ? ~sel : 1'b0;
            end else begin
                next_tp_ms = tp_ms + 8'h1;
            end
        end
        next_test_out = 2'h3;
        if (next_win) next_test_out[next_sel] = 1'b0;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            win <= 1'b0;
            sel <= 1'b0;
            tp_ms <= 8'h0;
            win_cnt <= 16'h0;
            o_test_out <= 2'h3;
        end else begin
            win <= next_win;
            sel <= next_sel;
            tp_ms <= next_tp_ms;
            win_cnt <= next_win_cnt;
            o_test_out <= next_test_out;
        end
    end

    // Contact filters, frozen while a test pulse is out
    logic filt [2];
    logic valid [2];
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_filt
            logic [7:0] cnt, next_cnt;
            logic next_filt, next_valid, samp;
            always_comb begin
                samp = win ? filt[ch] : stab[ch];
                next_cnt = cnt;
                next_filt = filt[ch];
                next_valid = valid[ch];
                if (samp == filt[ch] && valid[ch]) begin
                    next_cnt = 8'h0;
                end else if (ms_tick) begin
                    if (cnt + 8'h1 >= filt_eff) begin
                        next_filt = samp;
                        next_valid = 1'b1;
                        next_cnt = 8'h0;
                    end else begin
                        next_cnt = cnt + 8'h1;
                    end
                end
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cnt <= 8'h0;
                    filt[ch] <= 1'b0;
                    valid[ch] <= 1'b0;
                end else begin
                    cnt <= next_cnt;
                    filt[ch] <= next_filt;
                    valid[ch] <= next_valid;
                end
            end
        end
    endgenerate

    // Channel evaluation; NO contact on first channel reads inverted
    sim_state_e state, next_state;
    logic act1, act2, cond, all_off, disagree, all_valid, sim_to;
    always_comb begin
        act1 = mixed ? ~filt[0] : filt[0];
        act2 = filt[1];
        cond = act1 && (!two_ch || act2);
        all_off = !act1 && (!two_ch || !act2);
        // Filters not yet valid must not latch a fault at power-up
        disagree = two_ch && (state != ST_INIT) && (act1 != act2);
        all_valid = valid[0] && (!two_ch || valid[1]);
        tp_err = i_cable_test_enable && win_last && (state != ST_INIT) &&
                 (stab[sel] || (two_ch && (stab[~sel] != filt[~sel])));
    end

    // Simultaneity timer
    logic [7:0] sim_cnt, next_sim_cnt;
    always_comb begin
        next_sim_cnt = sim_cnt;
        sim_to = i_simul_enable && disagree && (sim_cnt >= i_simul_ms);
        if (!disagree || !i_simul_enable) next_sim_cnt = 8'h0;
        else if (ms_tick && sim_cnt != SIMUL_MAX)
            next_sim_cnt = sim_cnt + 8'h1;
    end

    // Fault latch and start-up test; set wins over release
    logic fault, next_fault, st_ok, next_st_ok;
    always_comb begin
        next_fault = fault;
        if (sim_to || tp_err) next_fault = 1'b1;
        else if (all_off) next_fault = 1'b0;
        next_st_ok = st_ok || !i_startup_test_enable ||
                     (state != ST_INIT && all_off);
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sim_cnt <= 8'h0;
            fault <= 1'b0;
            st_ok <= 1'b0;
        end else begin
            sim_cnt <= next_sim_cnt;
            fault <= next_fault;
            st_ok <= next_st_ok;
        end
    end

    // Output state machine with optional reset latch
    logic rst_q, rise, fall, ok;
    logic next_output, next_error;
    always_comb begin
        rise = stab[2] && !rst_q;
        fall = !stab[2] && rst_q;
        ok = cond && !fault && st_ok;
        next_state = state;
        unique case (state)
            ST_INIT: if (all_valid) next_state = ST_LOCKED;
            ST_LOCKED: begin
                if (ok) begin
                    if (!i_reset_enable) next_state = ST_RUN;
                    else if (rise && !i_reset_monitored)
                        next_state = ST_RUN;
                    else if (rise) next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!ok) next_state = ST_LOCKED;
                else if (fall) next_state = ST_RUN;
            end
            ST_RUN: if (!ok) next_state = ST_LOCKED;
        endcase
        next_output = (next_state == ST_RUN);
        next_error = i_error_enable && next_fault &&
                     (next_state != ST_INIT);
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_INIT;
            rst_q <= 1'b0;
            o_output <= 1'b0;
            o_error <= 1'b0;
        end else begin
            state <= next_state;
            rst_q <= stab[2];
            o_output <= next_output;
            o_error <= next_error;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_init_quiet;
        state == ST_INIT |=> !o_output && !o_error;
    endproperty
    a_init_quiet: assert property (p_init_quiet)
        else $error("output or error before first evaluation");

    property p_out_needs_cond;
        o_output |-> $past(cond) && $past(st_ok);
    endproperty
    a_out_needs_cond: assert property (p_out_needs_cond)
        else $error("output high without closed contacts");

    property p_two_nc;
        o_output && i_mode == MODE_ESTOP && i_input_type
            |-> $past(filt[0]) && $past(filt[1]);
    endproperty
    a_two_nc: assert property (p_two_nc)
        else $error("double NC output high with an open contact");

    property p_mixed;
        o_output && mixed |-> !$past(filt[0]) && $past(filt[1]);
    endproperty
    a_mixed: assert property (p_mixed)
        else $error("mixed contacts mapped wrongly");

    property p_direct;
        state == ST_LOCKED && ok && !i_reset_enable |=> o_output;
    endproperty
    a_direct: assert property (p_direct)
        else $error("output did not follow inputs without reset");

    property p_manual;
        $rose(o_output) && i_reset_enable && !i_reset_monitored
            |-> $past(rise);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual reset accepted without rising edge");

    property p_monitored;
        $rose(o_output) && i_reset_enable && i_reset_monitored
            |-> $past(state) == ST_ARMED && $past(fall);
    endproperty
    a_monitored: assert property (p_monitored)
        else $error("monitored reset accepted without fall");

    property p_startup;
        !st_ok |=> !o_output;
    endproperty
    a_startup: assert property (p_startup)
        else $error("output high before start-up test");

    property p_simul;
        sim_to |=> fault ##1 !o_output;
    endproperty
    a_simul: assert property (p_simul)
        else $error("simultaneity timeout did not force output low");

    property p_error;
        tp_err && i_error_enable && state != ST_INIT |=> o_error;
    endproperty
    a_error: assert property (p_error)
        else $error("fault not signalled on error output");

    property p_tick;
        ms_tick |=> !ms_tick;
    endproperty
    a_tick: assert property (p_tick)
        else $error("millisecond tick longer than one cycle");

    c_run: cover property (state == ST_LOCKED ##1 state == ST_RUN);
    c_armed: cover property (state == ST_ARMED ##[1:20] state == ST_RUN);
    c_fault: cover property ($rose(fault));

endmodule : sim_monitor

`default_nettype wire

// >>> shared/sim_pkg.sv
// Constants and types for the safety input monitor block.
// Assumes one 20 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// - E-stop mode: output 0 when pressed
// - E-stop takes one or two NC contacts
// - Dual interlock: output 0 while guard open
// - Mixed interlock: NO on first, NC second
// - Single interlock: one contact, 0 when open
// - Reset option latches output off after actuation
// - Manual reset: rising edge accepted
// - Monitored reset: rise then fall accepted
// - Test pulses detect cross-wired contact shorts
// - Start-up test: actuate and release once first
// - Contact filter between 3 and 250 ms
// - Optional simultaneity timeout between two channels
// - Error output flags detected faults

package sim_pkg;

    localparam int CLK_PERIOD_NS = 32'h32;
    localparam int MS_NS = 32'hf4240;
    localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int US_NS = 32'h3e8;
    localparam int TP_LEN_US = 32'h1f4;
    localparam int TP_LEN_CYC_DEF = (TP_LEN_US * US_NS) / CLK_PERIOD_NS;

    localparam logic [7:0] FILT_MIN_MS = 8'h03;
    localparam logic [7:0] FILT_MAX_MS = 8'hfa;
    localparam logic [7:0] TP_PERIOD_MS = 8'h64;
    localparam logic [7:0] SIMUL_MAX = 8'hff;

    localparam logic [1:0] MODE_ESTOP = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_SINGLE = 2'h2;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_LOCKED = 2'b01,
        ST_ARMED = 2'b10,
        ST_RUN = 2'b11
    } sim_state_e;

endpackage : sim_pkg

// >>> verification/sim_contacts.sv
// Field contacts fed from the monitor's test outputs.
// Assumes the bench sets closed flags; i_mixed makes channel 1 NO.
`timescale 1ns/1ps
`default_nettype none
module sim_contacts (
    input wire logic i_closed1,
    input wire logic i_closed2,
    input wire logic i_mixed,
    input wire logic i_short,
    input wire logic [1:0] i_test_out,
    output logic o_pin1,
    output logic o_pin2
);
    // NO contact conducts while the guard is open
    assign o_pin1 = (i_mixed ^ i_closed1) & i_test_out[0];
    // A short lets channel 1 feed leak into channel 2
    assign o_pin2 = i_closed2 &
        (i_short ? i_test_out[0] : i_test_out[1]);
endmodule : sim_contacts
`default_nettype wire

// >>> verification/sim_monitor_bench.sv
// Self-checking bench for the input monitor with contact model.
// Assumes short ms tick and test pulse parameters for run length.
`timescale 1ns/1ps
`default_nettype none
module sim_monitor_bench;
    import sim_pkg::*;
    localparam int TK = 20;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic c1 = 1'b0;
    logic c2 = 1'b0;
    logic shrt = 1'b0;
    logic rin = 1'b0;
    logic [8:0] cfg = 9'h000;
    logic [7:0] filt = 8'h03;
    logic [7:0] sms = 8'h02;
    logic mixed;
    logic p1;
    logic p2;
    logic o_output;
    logic o_error;
    logic [1:0] o_test_out;
    int seed = 32'h8948;
    int miscompares = 0;
    int samples_checked = 0;
    // Type, mode and option bits packed to keep setup to one write
    logic [8:0] tbl [5] = '{9'h000, 9'h040, 9'h080, 9'h0c0,
        9'h100};
    assign mixed = (cfg[8:6] === 3'b011);
    sim_contacts u_contacts (.i_closed1(c1), .i_closed2(c2),
        .i_mixed(mixed), .i_short(shrt), .i_test_out(o_test_out),
        .o_pin1(p1), .o_pin2(p2));
    sim_monitor #(.MS_CYC(TK), .TP_LEN_CYC(8)) DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_first_contact_input(p1), .i_second_contact_input(p2),
        .i_reset_input(rin),
        .i_mode(cfg[8:7]), .i_input_type(cfg[6]),
        .i_reset_enable(cfg[5]), .i_reset_monitored(cfg[4]),
        .i_startup_test_enable(cfg[3]), .i_cable_test_enable(cfg[2]),
        .i_simul_enable(cfg[1]), .i_error_enable(cfg[0]),
        .i_filter_ms(filt), .i_simul_ms(sms),
        .o_output(o_output), .o_error(o_error),
        .o_test_out(o_test_out));
    initial begin
        forever #25 i_clk = !i_clk;
    end
    function automatic int bnd(input logic [7:0] f);
        return (int'(f) + 3) * TK + 40;
    endfunction : bnd
    task automatic check(input logic [1:0] got, input logic [1:0] exp,
        input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic wait_out(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk);
            if (o_output === v) break;
        end
    endtask : wait_out
    task automatic start(input logic [8:0] c);
        @(posedge i_clk);
        cfg <= c;
        i_rst_n <= 1'b0;
        repeat (15) @(posedge i_clk);
        @(negedge i_clk);
        check(o_output, 1'b0, "out in reset");
        check(o_error, 1'b0, "err in reset");
        check(o_test_out, 2'h3, "test idle");
        @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask : start
    task automatic set_c(input logic a, input logic b);
        @(posedge i_clk);
        c1 <= a;
        c2 <= b;
    endtask : set_c
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked,
            miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge i_clk);
        miscompares++;
        end_sim();
    end
    initial begin
        foreach (tbl[k]) begin
            set_c(1'b1, 1'b1);
            filt <= 8'h03 + 8'({$random(seed)} % 8);
            start(tbl[k]);
            wait_out(1'b1, bnd(filt));
            check(o_output, 1'b1, "closed");
            set_c(1'b0, 1'b1);
            // Earliest legal drop is one ms short of the filter
            cyc((int'(filt) - 2) * TK);
            check(o_output, 1'b1, "filter");
            wait_out(1'b0, bnd(filt));
            check(o_output, 1'b0, "open");
        end
        $display("mode table done");
        set_c(1'b1, 1'b1);
        start(9'h0a0);
        cyc(bnd(filt));
        check(o_output, 1'b0, "no reset");
        @(posedge i_clk);
        rin <= 1'b1;
        wait_out(1'b1, 20);
        check(o_output, 1'b1, "manual");
        set_c(1'b1, 1'b0);
        rin <= 1'b0;
        cyc(bnd(filt));
        set_c(1'b1, 1'b1);
        cyc(bnd(filt));
        check(o_output, 1'b0, "relatch");
        $display("manual reset done");
        start(9'h0b0);
        cyc(bnd(filt));
        @(posedge i_clk);
        rin <= 1'b1;
        cyc(30);
        check(o_output, 1'b0, "rise only");
        @(posedge i_clk);
        rin <= 1'b0;
        wait_out(1'b1, 20);
        check(o_output, 1'b1, "fall");
        $display("monitored reset done");
        start(9'h088);
        cyc(bnd(filt));
        check(o_output, 1'b0, "startup");
        set_c(1'b0, 1'b0);
        cyc(bnd(filt));
        set_c(1'b1, 1'b1);
        wait_out(1'b1, bnd(filt));
        check(o_output, 1'b1, "after test");
        $display("startup done");
        set_c(1'b0, 1'b0);
        start(9'h083);
        cyc(bnd(filt));
        set_c(1'b1, 1'b0);
        cyc(bnd(filt) + 100);
        check(o_error, 1'b1, "skew err");
        set_c(1'b1, 1'b1);
        cyc(bnd(filt));
        check(o_output, 1'b0, "held off");
        set_c(1'b0, 1'b0);
        cyc(bnd(filt));
        check(o_error, 1'b0, "err clear");
        set_c(1'b1, 1'b1);
        wait_out(1'b1, bnd(filt));
        check(o_output, 1'b1, "in time");
        $display("simultaneity done");
        start(9'h085);
        wait_out(1'b1, bnd(filt));
        cyc(4500);
        check(o_output, 1'b1, "clean wires");
        check(o_error, 1'b0, "no wire error");
        @(posedge i_clk);
        shrt <= 1'b1;
        wait_out(1'b0, 4500);
        check(o_output, 1'b0, "short");
        check(o_error, 1'b1, "short error");
        $display("cable test done");
        end_sim();
    end
endmodule : sim_monitor_bench
`default_nettype wire
